// ---- rtl/gpc_cfg_bits.v ----
`timescale 1ns/10ps
// One 8-bit configuration register with a delayed sibling clear.
module gpc_cfg_bits #(
  parameter [7:0] RESET_VAL = 8'h00
) (
  input wire clk_i,
  input wire rst_i,
  input wire wr_i,
  input wire [7:0] wdata_i,
  input wire [7:0] clr_i,
  output wire [7:0] value_o
);
  reg [7:0] value_q;
  reg [7:0] clr_q;
  reg [7:0] value_d;

  always @* begin
    value_d = value_q & ~clr_q;
    if (wr_i) begin
      value_d = wdata_i;
    end
  end

  // The clear is staged one cycle so it shows on the second cycle after the write.
  always @(posedge clk_i) begin
    if (rst_i) begin
      value_q <= RESET_VAL;
      clr_q <= 8'h00;
    end else begin
      value_q <= value_d;
      clr_q <= clr_i;
    end
  end

  assign value_o = value_q;
endmodule

// ---- rtl/gpc_pad_config.v ----
// Chosen here: the Wishbone register port.
`timescale 1ns/10ps
`include "gpc_regs.vh"

module gpc_pad_config #(
  parameter [1:0] PORT_KIND = `GPC_PORT_OTHER
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [`GPC_ADDR_W-1:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire [7:0] alt_function_bits_o,
  output wire [7:0] drive_low_bits_o,
  output wire [7:0] drive_mid_bits_o,
  output wire [7:0] drive_high_bits_o,
  output wire [7:0] open_drain_bits_o,
  output wire [7:0] pull_up_bits_o,
  output wire [7:0] pull_down_bits_o,
  output wire [7:0] line_direction_o,
  output wire [7:0] od_input_o,
  output wire [7:0] od_output_o
);
  // ==========================================================================
  // Bus decode.
  localparam [7:0] ALT_RESET = (PORT_KIND == `GPC_PORT_B) ? `GPC_RST_ALT_PORT_B :
                               (PORT_KIND == `GPC_PORT_C) ? `GPC_RST_ALT_PORT_C :
                               `GPC_RST_ALT_DEFAULT;

  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // Only byte lane 0 holds data; upper lanes are ignored.
  wire wr = req & wb_we_i & wb_sel_i[0];
  wire [7:0] wd = wb_dat_i[7:0];

  reg wr_alt, wr_lo, wr_mid, wr_hi, wr_od, wr_pu, wr_pd, wr_dir;
  reg hit;
  always @* begin
    wr_alt = 1'b0;
    wr_lo = 1'b0;
    wr_mid = 1'b0;
    wr_hi = 1'b0;
    wr_od = 1'b0;
    wr_pu = 1'b0;
    wr_pd = 1'b0;
    wr_dir = 1'b0;
    hit = 1'b1;
    if (wb_adr_i == `GPC_OFF_ALT_FUNCTION_SELECT) begin
      wr_alt = wr;
    end else if (wb_adr_i == `GPC_OFF_DRIVE_LOW_SELECT) begin
      wr_lo = wr;
    end else if (wb_adr_i == `GPC_OFF_DRIVE_MID_SELECT) begin
      wr_mid = wr;
    end else if (wb_adr_i == `GPC_OFF_DRIVE_HIGH_SELECT) begin
      wr_hi = wr;
    end else if (wb_adr_i == `GPC_OFF_OPEN_DRAIN_SELECT) begin
      wr_od = wr;
    end else if (wb_adr_i == `GPC_OFF_PULL_UP_SELECT) begin
      wr_pu = wr;
    end else if (wb_adr_i == `GPC_OFF_PULL_DOWN_SELECT) begin
      wr_pd = wr;
    end else if (wb_adr_i == `GPC_OFF_LINE_DIRECTION) begin
      wr_dir = wr;
    end else begin
      hit = 1'b0;
    end
  end

  // ==========================================================================
  // Sibling clears: only ones written cause them, per bit position.
  wire [7:0] set_lo = wr_lo ? wd : 8'h00;
  wire [7:0] set_mid = wr_mid ? wd : 8'h00;
  wire [7:0] set_hi = wr_hi ? wd : 8'h00;
  wire [7:0] set_pu = wr_pu ? wd : 8'h00;
  wire [7:0] set_pd = wr_pd ? wd : 8'h00;

  wire [7:0] clr_lo = set_mid | set_hi;
  wire [7:0] clr_mid = set_lo | set_hi;
  wire [7:0] clr_hi = set_lo | set_mid;
  wire [7:0] clr_pu = set_pd;
  wire [7:0] clr_pd = set_pu;

  // ==========================================================================
  // Register bank.
  gpc_cfg_bits #(.RESET_VAL(ALT_RESET)) u_alt (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_alt),
    .wdata_i(wd),
    .clr_i(8'h00),
    .value_o(alt_function_bits_o)
  );

  gpc_cfg_bits #(.RESET_VAL(`GPC_RST_DRIVE_LOW)) u_lo (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_lo),
    .wdata_i(wd),
    .clr_i(clr_lo),
    .value_o(drive_low_bits_o)
  );

  gpc_cfg_bits #(.RESET_VAL(`GPC_RST_DRIVE_MID)) u_mid (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_mid),
    .wdata_i(wd),
    .clr_i(clr_mid),
    .value_o(drive_mid_bits_o)
  );

  gpc_cfg_bits #(.RESET_VAL(`GPC_RST_DRIVE_HIGH)) u_hi (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_hi),
    .wdata_i(wd),
    .clr_i(clr_hi),
    .value_o(drive_high_bits_o)
  );

  gpc_cfg_bits #(.RESET_VAL(`GPC_RST_OPEN_DRAIN)) u_od (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_od),
    .wdata_i(wd),
    .clr_i(8'h00),
    .value_o(open_drain_bits_o)
  );

  gpc_cfg_bits #(.RESET_VAL(`GPC_RST_PULL_UP)) u_pu (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_pu),
    .wdata_i(wd),
    .clr_i(clr_pu),
    .value_o(pull_up_bits_o)
  );

  gpc_cfg_bits #(.RESET_VAL(`GPC_RST_PULL_DOWN)) u_pd (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_pd),
    .wdata_i(wd),
    .clr_i(clr_pd),
    .value_o(pull_down_bits_o)
  );

  gpc_cfg_bits #(.RESET_VAL(`GPC_RST_DIRECTION)) u_dir (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wr_i(wr_dir),
    .wdata_i(wd),
    .clr_i(8'h00),
    .value_o(line_direction_o)
  );

  // ==========================================================================
  // Pad mode decode. The open-drain decode ignores the alternate-function bits.
  wire [7:0] sw_lines = ~alt_function_bits_o;
  assign od_input_o = open_drain_bits_o & ~line_direction_o;
  assign od_output_o = open_drain_bits_o & line_direction_o;

  // ==========================================================================
  // Read mux and acknowledge; unmapped addresses read zero and still ack.
  reg [7:0] rd;
  always @* begin
    rd = 8'h00;
    if (wb_adr_i == `GPC_OFF_ALT_FUNCTION_SELECT) begin
      rd = ~sw_lines;
    end else if (wb_adr_i == `GPC_OFF_DRIVE_LOW_SELECT) begin
      rd = drive_low_bits_o;
    end else if (wb_adr_i == `GPC_OFF_DRIVE_MID_SELECT) begin
      rd = drive_mid_bits_o;
    end else if (wb_adr_i == `GPC_OFF_DRIVE_HIGH_SELECT) begin
      rd = drive_high_bits_o;
    end else if (wb_adr_i == `GPC_OFF_OPEN_DRAIN_SELECT) begin
      rd = open_drain_bits_o;
    end else if (wb_adr_i == `GPC_OFF_PULL_UP_SELECT) begin
      rd = pull_up_bits_o;
    end else if (wb_adr_i == `GPC_OFF_PULL_DOWN_SELECT) begin
      rd = pull_down_bits_o;
    end else if (wb_adr_i == `GPC_OFF_LINE_DIRECTION) begin
      rd = line_direction_o;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= {`GPC_UPPER_READ, (hit ? rd : 8'h00)};
    end
  end
endmodule

// ---- rtl/gpc_regs.vh ----
`ifndef GPC_REGS_VH
`define GPC_REGS_VH
// ==========================================================================
// Register offsets (byte addresses within the port window).
`define GPC_OFF_ALT_FUNCTION_SELECT 12'h420
`define GPC_OFF_DRIVE_LOW_SELECT 12'h500
`define GPC_OFF_DRIVE_MID_SELECT 12'h504
`define GPC_OFF_DRIVE_HIGH_SELECT 12'h508
`define GPC_OFF_OPEN_DRAIN_SELECT 12'h50c
`define GPC_OFF_PULL_UP_SELECT 12'h510
`define GPC_OFF_PULL_DOWN_SELECT 12'h514
`define GPC_OFF_LINE_DIRECTION 12'h400
`define GPC_ADDR_W 12
// ==========================================================================
// Reset values.
`define GPC_RST_ALT_DEFAULT 8'h00
`define GPC_RST_ALT_PORT_B 8'h80
`define GPC_RST_ALT_PORT_C 8'h0f
`define GPC_RST_DRIVE_LOW 8'hff
`define GPC_RST_DRIVE_MID 8'h00
`define GPC_RST_DRIVE_HIGH 8'h00
`define GPC_RST_OPEN_DRAIN 8'h00
`define GPC_RST_PULL_UP 8'hff
`define GPC_RST_PULL_DOWN 8'h00
`define GPC_RST_DIRECTION 8'h00
// ==========================================================================
// Port kinds and bus constants.
`define GPC_PORT_OTHER 2'h0
`define GPC_PORT_B 2'h1
`define GPC_PORT_C 2'h2
`define GPC_UPPER_READ 24'h000000
`endif

// ---- testbench/gpc_checker.sv ----
`timescale 1ns/10ps
// ==========================================
// Bus timing, cross-clear, open-drain decode and reset-value checks.
module gpc_checker #(
  parameter [1:0] PORT_KIND = 2'h0
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire [7:0] alt_function_bits_o,
  input wire [7:0] drive_low_bits_o,
  input wire [7:0] drive_mid_bits_o,
  input wire [7:0] drive_high_bits_o,
  input wire [7:0] open_drain_bits_o,
  input wire [7:0] pull_up_bits_o,
  input wire [7:0] pull_down_bits_o,
  input wire [7:0] line_direction_o,
  input wire [7:0] od_input_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_wr(logic [11:0] a);
    wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0] && wb_adr_i == a;
  endsequence
  a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held too long");
  a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack late");
  a_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_low_clear: assert property (s_wr(12'h500) |-> ##2
    ((drive_mid_bits_o | drive_high_bits_o) & $past(wb_dat_i[7:0], 2)) == 8'h00)
    else $error("low drive write left a sibling set");
  a_mid_clear: assert property (s_wr(12'h504) |-> ##2
    ((drive_low_bits_o | drive_high_bits_o) & $past(wb_dat_i[7:0], 2)) == 8'h00)
    else $error("mid drive write left a sibling set");
  a_high_clear: assert property (s_wr(12'h508) |-> ##2
    ((drive_low_bits_o | drive_mid_bits_o) & $past(wb_dat_i[7:0], 2)) == 8'h00)
    else $error("high drive write left a sibling set");
  a_clear_late: assert property (s_wr(12'h504) |=> $stable(drive_low_bits_o))
    else $error("sibling cleared too early");
  a_pu_clear: assert property (s_wr(12'h510) |-> ##2
    (pull_down_bits_o & $past(wb_dat_i[7:0], 2)) == 8'h00)
    else $error("pull-up write left pull-down set");
  a_pd_clear: assert property (s_wr(12'h514) |-> ##2
    (pull_up_bits_o & $past(wb_dat_i[7:0], 2)) == 8'h00)
    else $error("pull-down write left pull-up set");
  a_od_decode: assert property (od_input_o == (open_drain_bits_o & ~line_direction_o))
    else $error("open-drain input decode wrong");
  a_reset_vals: assert property ($fell(rst_i) |-> drive_low_bits_o == 8'hff &&
    pull_up_bits_o == 8'hff && (drive_mid_bits_o | drive_high_bits_o | pull_down_bits_o |
    open_drain_bits_o) == 8'h00 && alt_function_bits_o ==
    (PORT_KIND == 2'h1 ? 8'h80 : PORT_KIND == 2'h2 ? 8'h0f : 8'h00))
    else $error("reset values wrong");
endmodule

bind gpc_pad_config gpc_checker #(.PORT_KIND(PORT_KIND)) chk_i (.*);

// ---- testbench/tb_top.sv ----
`timescale 1ns/10ps
// ==========================================
// Register access and pad control tests.
module tb_top;
  logic clk_i = 0, rst_i = 1, req = 0, we = 0, ack;
  logic [11:0] adr = 0;
  logic [3:0] sel = 0;
  logic [31:0] dat = 0, rdat, dout;
  logic [7:0] alt, lo, mid, hi, od, pu, pd, dir, odi, odo;
  int errors = 0, checks_done = 0, cycles = 0;
  logic [11:0] offs[9] = '{12'h420, 12'h500, 12'h504, 12'h508, 12'h50c, 12'h510,
    12'h514, 12'h400, 12'h600};
  logic [7:0] rstv[9] = '{8'h0f, 8'hff, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
  gpc_pad_config #(.PORT_KIND(2'h2)) uut (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack), .alt_function_bits_o(alt),
    .drive_low_bits_o(lo), .drive_mid_bits_o(mid), .drive_high_bits_o(hi),
    .open_drain_bits_o(od), .pull_up_bits_o(pu), .pull_down_bits_o(pd),
    .line_direction_o(dir), .od_input_o(odi), .od_output_o(odo));
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      errors++;
      report_and_stop;
    end
  end
  task report_and_stop;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    req <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    do @(posedge clk_i); while (ack !== 1'b1 && cycles < 2000);
    rdat = dout;
    req <= 0;
    @(posedge clk_i);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'h1);
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    xfer(1'b0, a, 32'h0, 4'hf);
    chk($sformatf("reg %h", a), {24'h000000, e}, rdat);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    foreach (offs[i]) rd(offs[i], rstv[i]);
    $display("test reset done");
    wr(12'h504, 32'h0f);
    wr(12'h508, 32'h03);
    wr(12'h500, 32'hffffff01);
    rd(12'h500, 8'h01);
    rd(12'h504, 8'h0c);
    rd(12'h508, 8'h02);
    $display("test drive done");
    wr(12'h514, 32'h0f);
    wr(12'h510, 32'h03);
    rd(12'h510, 8'h03);
    rd(12'h514, 8'h0c);
    $display("test pull done");
    wr(12'h50c, 32'h0f);
    wr(12'h400, 32'h05);
    chk("od pads", 32'h0a05, {16'h0000, odi, odo});
    wr(12'h420, 32'ha5);
    chk("alt pads", 32'ha5, {24'h000000, alt});
    xfer(1'b1, 12'h500, 32'h3c, 4'h0);
    wr(12'h600, 32'hff);
    rd(12'h500, 8'h01);
    rd(12'h600, 8'h00);
    $display("test modes done");
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    chk("alt after reset", 32'h0f, {24'h000000, alt});
    rd(12'h500, 8'hff);
    rd(12'h510, 8'hff);
    rd(12'h50c, 8'h00);
    $display("test rerun reset done");
    report_and_stop;
  end
endmodule
